// ---- inc/pwm_dt_pkg.sv ----
// constants for the deadtime, pair combine and trigger control block
package pwm_dt_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int NUM_CH = 8;
   localparam int NUM_PAIRS = 4;
   localparam int DT_W = 6;
   localparam int PRE_W = 4;
   localparam int CNT_W = 16;

   // register byte offsets
   localparam logic [11:0] MODE_OFF = 12'h054;
   localparam logic [11:0] PAIR_CFG_OFF = 12'h064;
   localparam logic [11:0] DT_CTRL_OFF = 12'h068;
   localparam logic [11:0] TRIG_OFF = 12'h06c;

   // mode register fields
   localparam int WRITE_PROTECT_DISABLE_POS = 2;
   localparam logic WRITE_PROTECT_DISABLE_RESET = 1'b1;

   // pair configuration: one byte per pair
   localparam int PAIR_STRIDE = 8;
   localparam int COMBINE_POS = 0;
   localparam int COMP_POS = 1;
   localparam int DTEN_POS = 4;
   localparam logic [31:0] PAIR_CFG_RESET = 32'h0000_0000;

   // deadtime control fields
   localparam int DT_VAL_LSB = 0;
   localparam int DT_PS_LSB = 6;
   localparam logic [7:0] DT_CTRL_RESET = 8'h00;

   // trigger register fields
   localparam int CHANNEL_TRIGGER_FLAG_POS = 7;
   localparam int INIT_EN_POS = 6;
   localparam int TRIG_CH0_POS = 4;
   localparam int TRIG_CH1_POS = 5;
   localparam int TRIG_CH2_POS = 0;
   localparam int TRIG_CH3_POS = 1;
   localparam int TRIG_CH4_POS = 2;
   localparam int TRIG_CH5_POS = 3;
   localparam logic [6:0] TRIG_CFG_RESET = 7'h00;

   // prescaler selections and their division factors
   localparam logic [1:0] DT_PS_DIV4 = 2'b10;
   localparam logic [1:0] DT_PS_DIV16 = 2'b11;
   localparam int DT_DIV1 = 1;
   localparam int DT_DIV4 = 4;
   localparam int DT_DIV16 = 16;
endpackage : pwm_dt_pkg

// ---- rtl/pwm_deadtime_trigger_control.sv ----
// pair combine, shared deadtime insertion and trigger control, apb slave
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps

module pwm_deadtime_trigger_control
   import pwm_dt_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [pwm_dt_pkg::CNT_W-1:0] COUNTER_VALUE,
   input wire logic [pwm_dt_pkg::CNT_W-1:0] COUNTER_INITIAL_VALUE,
   input wire logic [pwm_dt_pkg::NUM_CH-1:0] CH_MATCH,
   input wire logic [pwm_dt_pkg::NUM_CH-1:0] CH_PWM_IN,
   output logic [pwm_dt_pkg::NUM_CH-1:0] PWM_OUT,
   output logic TRIGGER_OUT
);
   import pwm_dt_pkg::*;

   // prescaler terminal count for a selection
   function automatic logic [PRE_W-1:0] pre_max_f(input logic [1:0] sel);
      logic [PRE_W-1:0] r;
      r = PRE_W'(DT_DIV1 - 1);
      if (sel == DT_PS_DIV4) begin
         r = PRE_W'(DT_DIV4 - 1);
      end else if (sel == DT_PS_DIV16) begin
         r = PRE_W'(DT_DIV16 - 1);
      end
      return r;
   endfunction

   // reset release through two flip-flops
   logic [1:0] rst_sync_reg;
   logic rst_n;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // register state
   logic write_protect_disable_reg;
   logic [31:0] pair_cfg_reg;
   logic [7:0] dt_ctrl_reg;
   logic [6:0] trig_cfg_reg;
   logic channel_trigger_flag_reg, channel_trigger_flag_next;
   logic clr_armed_reg, clr_armed_next;
   logic pready_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;

   // apb decode: one wait state, transfer ends on second access cycle
   wire access = PSEL & PENABLE;
   wire fire = access & pready_reg;
   wire wr_fire = fire & PWRITE;
   wire rd_fire = fire & ~PWRITE;
   wire hit_mode = (PADDR == MODE_OFF);
   wire hit_pair = (PADDR == PAIR_CFG_OFF);
   wire hit_dt = (PADDR == DT_CTRL_OFF);
   wire hit_trig = (PADDR == TRIG_OFF);
   wire mapped = hit_mode | hit_pair | hit_dt | hit_trig;
   wire wr_mode = wr_fire & hit_mode;
   wire wr_pair = wr_fire & hit_pair;
   wire wr_dt = wr_fire & hit_dt;
   wire wr_trig = wr_fire & hit_trig;
   wire rd_trig = rd_fire & hit_trig;

   // writable bits of the pair register
   logic [31:0] pair_mask;
   for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_mask
      assign pair_mask[p*PAIR_STRIDE +: PAIR_STRIDE] =
         PAIR_STRIDE'((1 << COMBINE_POS) | (1 << COMP_POS) |
                      (1 << DTEN_POS));
   end

   // read data mux; unused bits read as zero
   logic [31:0] rd_data;
   assign rd_data = hit_mode ? 32'(write_protect_disable_reg) << WRITE_PROTECT_DISABLE_POS :
                    hit_pair ? pair_cfg_reg :
                    hit_dt ? {24'h000000, dt_ctrl_reg} :
                    hit_trig ? {24'h000000, channel_trigger_flag_reg, trig_cfg_reg} :
                    32'h0000_0000;

   // apb handshake and read capture
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         pready_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= access & ~pready_reg;
         prdata_reg <= (access & ~pready_reg & ~PWRITE) ? rd_data
                                                        : 32'h0000_0000;
         pslverr_reg <= access & ~pready_reg & ~mapped;
      end
   end
   assign PREADY = pready_reg;
   assign PRDATA = prdata_reg;
   assign PSLVERR = pslverr_reg;

   // configuration registers; protected fields need write_protect_disable
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         write_protect_disable_reg <= WRITE_PROTECT_DISABLE_RESET;
         pair_cfg_reg <= PAIR_CFG_RESET;
         dt_ctrl_reg <= DT_CTRL_RESET;
         trig_cfg_reg <= TRIG_CFG_RESET;
      end else begin
         if (wr_mode) begin
            write_protect_disable_reg <= PWDATA[WRITE_PROTECT_DISABLE_POS];
         end
         if (wr_pair && write_protect_disable_reg) begin
            pair_cfg_reg <= PWDATA & pair_mask;
         end
         if (wr_dt && write_protect_disable_reg) begin
            dt_ctrl_reg <= PWDATA[7:0];
         end
         if (wr_trig) begin
            trig_cfg_reg <= PWDATA[6:0];
         end
      end
   end

   // shared deadtime settings
   wire [1:0] dt_ps = dt_ctrl_reg[DT_PS_LSB +: 2];
   wire [DT_W-1:0] dt_val = dt_ctrl_reg[DT_VAL_LSB +: DT_W];
   wire [PRE_W-1:0] pre_max = pre_max_f(dt_ps);

   // channel trigger enables mapped onto channels, 6 and 7 tied off
   logic [NUM_CH-1:0] ch_trig_en;
   assign ch_trig_en = {2'b00,
                        trig_cfg_reg[TRIG_CH5_POS],
                        trig_cfg_reg[TRIG_CH4_POS],
                        trig_cfg_reg[TRIG_CH3_POS],
                        trig_cfg_reg[TRIG_CH2_POS],
                        trig_cfg_reg[TRIG_CH1_POS],
                        trig_cfg_reg[TRIG_CH0_POS]};
   wire chan_trig = |(CH_MATCH & ch_trig_en);

   // init trigger on the cycle the counter reaches its initial value
   logic init_eq_reg;
   wire init_eq = (COUNTER_VALUE == COUNTER_INITIAL_VALUE);
   wire init_fire = trig_cfg_reg[INIT_EN_POS] & init_eq & ~init_eq_reg;

   // flag clear sequence: read while set arms, write 0 clears
   always_comb begin
      channel_trigger_flag_next = channel_trigger_flag_reg;
      clr_armed_next = clr_armed_reg;
      if (rd_trig && channel_trigger_flag_reg) begin
         clr_armed_next = 1'b1;
      end
      if (wr_trig && clr_armed_reg && !PWDATA[CHANNEL_TRIGGER_FLAG_POS]) begin
         channel_trigger_flag_next = 1'b0;
         clr_armed_next = 1'b0;
      end
      if (chan_trig) begin
         channel_trigger_flag_next = 1'b1;
         clr_armed_next = 1'b0;
      end
   end

   // trigger flag, trigger pulse output
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         channel_trigger_flag_reg <= 1'b0;
         clr_armed_reg <= 1'b0;
         init_eq_reg <= 1'b0;
         TRIGGER_OUT <= 1'b0;
      end else begin
         channel_trigger_flag_reg <= channel_trigger_flag_next;
         clr_armed_reg <= clr_armed_next;
         init_eq_reg <= init_eq;
         TRIGGER_OUT <= chan_trig | init_fire;
      end
   end

   // source and deadtime enable of every output, per pair
   logic [NUM_CH-1:0] src;
   logic [NUM_CH-1:0] dten;
   for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
      wire comb = pair_cfg_reg[p*PAIR_STRIDE + COMBINE_POS];
      wire comp = pair_cfg_reg[p*PAIR_STRIDE + COMP_POS];
      wire den = pair_cfg_reg[p*PAIR_STRIDE + DTEN_POS];
      assign src[2*p] = CH_PWM_IN[2*p];
      assign src[2*p+1] = comb ? (CH_PWM_IN[2*p] ^ comp)
                               : CH_PWM_IN[2*p+1];
      assign dten[2*p] = den;
      assign dten[2*p+1] = den;
   end

   // per output delay of the asserting edge
   logic [DT_W-1:0] dt_cnt_reg [NUM_CH];
   logic [PRE_W-1:0] pre_cnt_reg [NUM_CH];
   for (genvar i = 0; i < NUM_CH; i++) begin : g_out
      wire done = (dt_cnt_reg[i] >= dt_val);
      wire tick = (pre_cnt_reg[i] >= pre_max);
      always_ff @(posedge CLOCK or negedge rst_n) begin
         if (!rst_n) begin
            dt_cnt_reg[i] <= '0;
            pre_cnt_reg[i] <= '0;
            PWM_OUT[i] <= 1'b0;
         end else if (!src[i]) begin
            dt_cnt_reg[i] <= '0;
            pre_cnt_reg[i] <= '0;
            PWM_OUT[i] <= 1'b0;
         end else if (!dten[i] || done) begin
            PWM_OUT[i] <= 1'b1;
         end else begin
            PWM_OUT[i] <= 1'b0;
            pre_cnt_reg[i] <= tick ? '0 : pre_cnt_reg[i] + 1'b1;
            if (tick) begin
               dt_cnt_reg[i] <= dt_cnt_reg[i] + 1'b1;
            end
         end
      end
   end

   // checks
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!rst_n);

   AST_WP_PAIR: assert property (
      wr_pair && !write_protect_disable_reg |=> $stable(pair_cfg_reg))
      else $error("pair config changed while write protected");

   AST_WP_DT: assert property (
      wr_dt && !write_protect_disable_reg |=> $stable(dt_ctrl_reg))
      else $error("deadtime control changed while write protected");

   AST_RSVD_DT: assert property (
      access && !pready_reg && !PWRITE && hit_dt
      |=> PREADY && PRDATA[31:8] == 24'h000000)
      else $error("deadtime reserved bits read non-zero");

   AST_FLAG_SET: assert property (
      chan_trig |=> channel_trigger_flag_reg && TRIGGER_OUT)
      else $error("channel trigger did not set flag");

   AST_INIT_TRIG: assert property (
      trig_cfg_reg[INIT_EN_POS] && $rose(init_eq) |=> TRIGGER_OUT)
      else $error("init trigger missing");

   AST_NO_CH67: assert property (
      CH_MATCH[5:0] == 6'h00 |-> !chan_trig)
      else $error("trigger from channel 6 or 7");

   AST_W1_NOEFFECT: assert property (
      wr_trig && PWDATA[CHANNEL_TRIGGER_FLAG_POS] && !channel_trigger_flag_reg && !chan_trig
      |=> !channel_trigger_flag_reg)
      else $error("writing one set the trigger flag");

   AST_CLR_NEEDS_READ: assert property (
      wr_trig && !clr_armed_reg && channel_trigger_flag_reg |=> channel_trigger_flag_reg)
      else $error("flag cleared without prior read");

   AST_INDEP: assert property (
      !pair_cfg_reg[COMBINE_POS] && !pair_cfg_reg[DTEN_POS]
      |=> PWM_OUT[1] == $past(CH_PWM_IN[1]))
      else $error("independent channel 1 output wrong");

   AST_COMP: assert property (
      pair_cfg_reg[COMBINE_POS] && pair_cfg_reg[COMP_POS] &&
      !pair_cfg_reg[DTEN_POS]
      |=> PWM_OUT[1] == !$past(CH_PWM_IN[0]))
      else $error("complement output wrong");

   AST_PRESC: assert property (
      pre_cnt_reg[0] <= pre_max || $changed(dt_ps))
      else $error("prescaler count beyond terminal");

   AST_DT_LEN: assert property (
      $rose(PWM_OUT[0]) && dten[0] && $stable(dt_val)
      |-> dt_cnt_reg[0] == dt_val)
      else $error("deadtime count at edge differs from value");

   AST_DT_ONE: assert property (
      dten[0] && dt_val == 6'h01 && dt_ps == 2'b00 && $rose(src[0])
      ##1 src[0] |-> !PWM_OUT[0] ##1 PWM_OUT[0])
      else $error("single count deadtime wrong length");

   AST_EXCL: assert property (
      pair_cfg_reg[COMBINE_POS] && pair_cfg_reg[COMP_POS] && dten[0] &&
      dt_val != 6'h00 && $stable(pair_cfg_reg) && $stable(dt_val)
      |-> !(PWM_OUT[0] && PWM_OUT[1]))
      else $error("both outputs of pair 0 active");

   // zero count passes the asserting edge straight through
   AST_DT_ZERO: assert property (
      dten[0] && dt_val == 6'h00 && src[0] |=> PWM_OUT[0])
      else $error("zero deadtime delayed the output");

   AST_NO_DT: assert property (
      !dten[0] && src[0] |=> PWM_OUT[0])
      else $error("output delayed with deadtime disabled");

   // deasserting edge is never delayed
   AST_FALL: assert property (
      !src[1] |=> !PWM_OUT[1])
      else $error("output stayed active after source fell");

   AST_READ_ARMS: assert property (
      rd_trig && channel_trigger_flag_reg && !chan_trig |=> clr_armed_reg)
      else $error("read of set flag did not arm the clear");

   AST_CLEAR: assert property (
      wr_trig && clr_armed_reg && !PWDATA[CHANNEL_TRIGGER_FLAG_POS] && !chan_trig
      |=> !channel_trigger_flag_reg)
      else $error("armed write of zero did not clear flag");

   // no trigger pulse without a channel or init cause
   AST_TRIG_CAUSE: assert property (
      TRIGGER_OUT |-> $past(chan_trig) || $past(init_fire))
      else $error("trigger pulse without a cause");

endmodule // pwm_deadtime_trigger_control

// ---- verification/gate_driver_model.sv ----
// gate driver model: counts cycles with both gates of a watched pair on
`timescale 1ns/1ps
module gate_driver_model
   import pwm_dt_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic [pwm_dt_pkg::NUM_CH-1:0] gates,
   input wire logic [pwm_dt_pkg::NUM_PAIRS-1:0] watch,
   output logic [7:0] overlaps
);
   // shoot-through on a watched pair would wreck the power stage
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         overlaps <= 8'h00;
      end else begin
         for (int p = 0; p < NUM_PAIRS; p++) begin
            if (watch[p] && gates[2*p] && gates[2*p+1]) begin
               overlaps <= overlaps + 8'h01;
            end
         end
      end
   end
endmodule // gate_driver_model

// ---- verification/pwm_deadtime_trigger_control_test.sv ----
// self-checking bench for the deadtime, pair and trigger control block
`timescale 1ns/1ps
module pwm_deadtime_trigger_control_test;
   import pwm_dt_pkg::*;
   localparam logic RD = 1'h0;
   localparam logic WR = 1'h1;
   logic CLOCK = 1'h0, RSTN = 1'h0;
   logic PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic PREADY, PSLVERR, TRIGGER_OUT, err;
   logic [CNT_W-1:0] COUNTER_VALUE = 16'h0, COUNTER_INITIAL_VALUE = 16'h5;
   logic [7:0] CH_MATCH = 8'h0, CH_PWM_IN = 8'h0, PWM_OUT, overlaps;
   logic [3:0] watch = 4'h0;
   int num_errors = 0, samples_checked = 0;
   always #12.5 CLOCK = ~CLOCK;
   pwm_deadtime_trigger_control i_pwm_deadtime_trigger_control (
      .CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .COUNTER_VALUE(COUNTER_VALUE),
      .COUNTER_INITIAL_VALUE(COUNTER_INITIAL_VALUE), .CH_MATCH(CH_MATCH),
      .CH_PWM_IN(CH_PWM_IN), .PWM_OUT(PWM_OUT), .TRIGGER_OUT(TRIGGER_OUT));
   gate_driver_model i_gate_driver_model (.clock(CLOCK), .rstn(RSTN),
      .gates(PWM_OUT), .watch(watch), .overlaps(overlaps));
   task automatic stop_test();
      $display("errors=%0d checks=%0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic hang();
      num_errors++;
      stop_test();
   endtask
   // one apb transfer, waits for pready under a bound
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge CLOCK);
      PSEL <= 1'h1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'h1;
      n = 0;
      do begin
         @(posedge CLOCK);
         n++;
      end while (PREADY !== 1'h1 && n < 100);
      if (PREADY !== 1'h1) hang();
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
   endtask
   // edges from a source change until output o reaches level l
   task automatic meas(input int i, input logic v, input int o,
                       input logic l, input int e);
      int n;
      @(posedge CLOCK);
      CH_PWM_IN[i] <= v;
      n = 0;
      do begin
         @(posedge CLOCK);
         #1;
         n++;
      end while (PWM_OUT[o] !== l && n < 2000);
      chk(32'(n), 32'(e));
      if (PWM_OUT[o] !== l) hang();
   endtask
   task automatic pulse(input logic [7:0] m, input logic e);
      @(posedge CLOCK);
      CH_MATCH <= m;
      @(posedge CLOCK);
      CH_MATCH <= 8'h00;
      #1;
      chk({31'h0, TRIGGER_OUT}, {31'h0, e});
   endtask
   task automatic t_reset();
      apb(RD, DT_CTRL_OFF, 32'h0);
      chk(rd, 32'(DT_CTRL_RESET));
      apb(RD, TRIG_OFF, 32'h0);
      chk(rd, 32'h0);
      apb(RD, PAIR_CFG_OFF, 32'h0);
      chk(rd, PAIR_CFG_RESET);
      apb(RD, MODE_OFF, 32'h0);
      chk(rd & 32'h4, 32'h4);
   endtask
   task automatic t_regs();
      apb(WR, DT_CTRL_OFF, 32'hffff_ff41);
      apb(RD, DT_CTRL_OFF, 32'h0);
      chk(rd, 32'h41);
      apb(RD, 12'h0f0, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      apb(WR, MODE_OFF, 32'h0);
      apb(WR, DT_CTRL_OFF, 32'h0);
      apb(WR, PAIR_CFG_OFF, 32'h11);
      apb(RD, DT_CTRL_OFF, 32'h0);
      chk(rd, 32'h41);
      apb(RD, PAIR_CFG_OFF, 32'h0);
      chk(rd, 32'h0);
      apb(WR, MODE_OFF, 32'h1 << WRITE_PROTECT_DISABLE_POS);
      apb(WR, PAIR_CFG_OFF, 32'h11);
      apb(RD, PAIR_CFG_OFF, 32'h0);
      chk(rd, 32'h11);
   endtask
   task automatic t_deadtime();
      logic [7:0] tab [7] = '{8'h00, 8'h01, 8'h03, 8'h43, 8'h83,
                              8'hff, 8'hc3};
      int div;
      apb(WR, PAIR_CFG_OFF, 32'h10);
      foreach (tab[k]) begin
         div = tab[k][7] ? (tab[k][6] ? DT_DIV16 : DT_DIV4) : DT_DIV1;
         apb(WR, DT_CTRL_OFF, {24'h0, tab[k]});
         meas(0, 1'h1, 0, 1'h1, 1 + div * int'(tab[k][5:0]));
         meas(0, 1'h0, 0, 1'h0, 1);
      end
      apb(WR, PAIR_CFG_OFF, 32'h0010_0010);
      meas(4, 1'h1, 4, 1'h1, 1 + DT_DIV16 * 3);
      meas(4, 1'h0, 4, 1'h0, 1);
      meas(2, 1'h1, 2, 1'h1, 1);
      meas(2, 1'h0, 2, 1'h0, 1);
   endtask
   task automatic t_pairs();
      apb(WR, PAIR_CFG_OFF, 32'h03);
      meas(0, 1'h1, 1, 1'h0, 1);
      meas(0, 1'h0, 1, 1'h1, 1);
      apb(WR, PAIR_CFG_OFF, 32'h01);
      meas(0, 1'h1, 1, 1'h1, 1);
      meas(0, 1'h0, 1, 1'h0, 1);
      apb(WR, PAIR_CFG_OFF, 32'h00);
      meas(1, 1'h1, 1, 1'h1, 1);
      meas(1, 1'h0, 1, 1'h0, 1);
      apb(WR, DT_CTRL_OFF, 32'h02);
      apb(WR, PAIR_CFG_OFF, 32'h13);
      watch <= 4'h1;
      meas(0, 1'h1, 0, 1'h1, 3);
      meas(0, 1'h0, 1, 1'h1, 3);
      chk({24'h0, overlaps}, 32'h0);
      watch <= 4'h0;
   endtask
   task automatic t_trig();
      int pos [6] = '{TRIG_CH0_POS, TRIG_CH1_POS, TRIG_CH2_POS,
                      TRIG_CH3_POS, TRIG_CH4_POS, TRIG_CH5_POS};
      foreach (pos[k]) begin
         apb(WR, TRIG_OFF, 32'h1 << pos[k]);
         pulse(8'h01 << k, 1'h1);
         pulse(~(8'h01 << k) & 8'h3f, 1'h0);
      end
      apb(WR, TRIG_OFF, 32'h3f);
      pulse(8'hc0, 1'h0);
      apb(WR, TRIG_OFF, 32'h3f);
      apb(RD, TRIG_OFF, 32'h0);
      chk(rd, 32'hbf);
      apb(WR, TRIG_OFF, 32'h3f);
      apb(RD, TRIG_OFF, 32'h0);
      chk(rd, 32'h3f);
      apb(WR, TRIG_OFF, 32'hbf);
      apb(RD, TRIG_OFF, 32'h0);
      chk(rd, 32'h3f);
      apb(WR, TRIG_OFF, 32'h40);
      @(posedge CLOCK);
      COUNTER_VALUE <= COUNTER_INITIAL_VALUE;
      repeat (2) @(posedge CLOCK);
      chk({31'h0, TRIGGER_OUT}, 32'h1);
      @(posedge CLOCK);
      chk({31'h0, TRIGGER_OUT}, 32'h0);
      apb(RD, TRIG_OFF, 32'h0);
      chk(rd, 32'h40);
   endtask
   // reset, then each scenario in turn
   initial begin
      repeat (5) @(posedge CLOCK);
      RSTN <= 1'h1;
      repeat (3) @(posedge CLOCK);
      t_reset();
      t_regs();
      t_deadtime();
      t_pairs();
      t_trig();
      stop_test();
   end
endmodule // pwm_deadtime_trigger_control_test
